/* File: common/fspc_map.svh */
`ifndef FSPC_MAP_SVH
`define FSPC_MAP_SVH
// Behaviour
// R1 - Pattern X0000011 then store within four cycles starts page erase; data ignored.
// R2 - Software puts page number in page field, other pointer bits zero.
// R3 - Erase in read-while-write section keeps other readable; else halts cpu.
// R4 - Pattern 00000001 then store loads data pair into buffer slot by word field.
// R5 - Buffer clears after page write, on section re-enable, and on reset.
// R6 - Software loads each buffer slot at most once between clears.
// R7 - Eeprom write during partial buffer load discards all loaded words.
// R8 - Pattern X0000101 then store within four cycles starts page write.
// R9 - Page write to read-while-write section keeps other readable; else halts cpu.
// R10 - Enabled completion interrupt stays asserted while store enable is clear.
// R11 - Erase or write blocks read-while-write section reads and holds section busy.
// R12 - Section busy stays set until software issues section re-enable.
// R13 - Pattern X0001001 then store programs boot lock bits from low data.
// R14 - Zeros in low data bits 5:2 program lock bits; pointer ignored.
// R15 - Software should use pointer 0x0001 and set data bits 7,6,1,0.
// R16 - Lock programming leaves all flash readable and never halts.
// R17 - During eeprom write all programming commands and fuse readback refused; code refuses control writes, fuse reads; an armed sequence still starts.
// R18 - Software should check eeprom busy clear before writing control.
// R19 - Software erases before writing, same page address for both.
// R20 - Buffer accepts word loads in any order.
// R21 - Software should disable interrupts before the timed sequence.
// R22 - Without store within four cycles, armed bits including store enable clear.
// R23 - Address captured from pointer when an operation starts.
// R24 - Erase, write and lock programming take 3.7 ms to 4.5 ms.
// R25 - Store enable clears when any operation completes.

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define FSPC_BIT_IE      7
`define FSPC_BIT_BUSY    6
`define FSPC_BIT_REENABLE 4
`define FSPC_BIT_LOCK    3
`define FSPC_BIT_WRITE   2
`define FSPC_BIT_ERASE   1
`define FSPC_BIT_STORE_EN 0
`define FSPC_CMD_LOAD    5'h01
`define FSPC_CMD_ERASE   5'h03
`define FSPC_CMD_WRITE   5'h05
`define FSPC_CMD_LOCK    5'h09
`define FSPC_CMD_REENABLE 5'h11
`define FSPC_CTRL_RESET  8'h00
`define FSPC_LOCK_RESET  4'hf

// ----------------------------------------
// Timing
// ----------------------------------------
`define FSPC_ARM_WINDOW  4
`define FSPC_CLK_MHZ     200
`define FSPC_PROG_MIN_US 3700
`define FSPC_PROG_MAX_US 4500
`endif

/* File: common/fspc_pkg.sv */
package fspc_pkg;
    typedef enum logic [1:0] {
        FSPC_OP_ERASE,
        FSPC_OP_WRITE,
        FSPC_OP_LOCK
    } fspc_op_t;

    typedef struct packed {
        logic [7:0] data;
        logic wr;
    } fspc_ctrl_wr_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic store;
    } fspc_store_t;

    typedef struct packed {
        logic go;
        fspc_op_t op;
        logic [15:0] addr;
    } fspc_prog_t;
endpackage

/* File: rtl/fspc_timer.sv */
`timescale 1ns/1ps
`include "fspc_map.svh"
// ----------------------------------------
// Programming time counter
// ----------------------------------------
module fspc_timer #(
    parameter int CYCLES = `FSPC_CLK_MHZ * `FSPC_PROG_MIN_US
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    output logic done
);
    logic [31:0] cnt_q;
    logic run_q;
    wire last = run_q && (cnt_q == 32'(CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= 32'h0;
            run_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= last;
            if (start) begin
                run_q <= 1'b1;
                cnt_q <= 32'h0;
            end else if (last) begin
                run_q <= 1'b0;
            end else if (run_q) begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end
endmodule

/* File: rtl/fspc_ctrl.sv */
`timescale 1ns/1ps
`include "fspc_map.svh"
module fspc_ctrl #(
    // Minimum time, clk at 200 MHz; lies inside 3.7 to 4.5 ms
    parameter int PROG_CYCLES = `FSPC_CLK_MHZ * `FSPC_PROG_MIN_US, // R24
    parameter int PAGE_WORDS = 128,
    parameter int WORD_BITS = 7,
    // Pages from here up halt the core; a 16-bit pointer reaches only 256 pages
    parameter int READ_WHILE_WRITE_PAGES = 192
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Core side
    input wire fspc_pkg::fspc_ctrl_wr_t ctrl_wr,
    input wire fspc_pkg::fspc_store_t store,
    input wire logic [4:0] buf_rd_idx,
    input wire logic eeprom_write_busy_bit,
    input wire logic fuse_read_req,
    // Status
    output logic [7:0] flash_prog_control_reg,
    output logic irq,
    output logic cpu_halt,
    output logic rww_read_block,
    output logic fuse_read_allow,
    output logic [3:0] boot_lock_bits,
    // Flash array side
    output fspc_pkg::fspc_prog_t prog,
    output logic [15:0] buf_rd_data
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [1:0] {
        FSPC_IDLE,
        FSPC_ARMED,
        FSPC_BUSY
    } fspc_st_t;

    fspc_st_t st_q;
    logic [7:0] ctl_q;
    logic [2:0] arm_cnt_q;
    logic busy_q;
    logic halt_sect_q;
    logic [15:0] page_buf_q [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] valid_q;
    logic done;
    logic [15:0] buf_rd_q;

    wire logic [4:0] cmd = ctl_q[4:0];
    wire logic st_go = (st_q == FSPC_ARMED) && store.store;
    wire logic is_erase = cmd == `FSPC_CMD_ERASE;
    wire logic is_write = cmd == `FSPC_CMD_WRITE;
    wire logic is_lock = cmd == `FSPC_CMD_LOCK;
    wire logic is_load = cmd == `FSPC_CMD_LOAD;
    wire logic is_reenable = cmd == `FSPC_CMD_REENABLE;
    wire logic [WORD_BITS-1:0] word_idx = store.addr[WORD_BITS:1];
    wire logic [15:0] page_no = 16'(store.addr >> (WORD_BITS + 1));
    wire logic start_prog = st_go && (is_erase || is_write); // R1 R8
    wire logic start_lock = st_go && is_lock; // R13
    // Eeprom write refuses any arming of the control register
    wire logic ctl_take = ctrl_wr.wr && !eeprom_write_busy_bit && st_q != FSPC_BUSY; // R17
    wire logic arm_out = (st_q == FSPC_ARMED) && !store.store
        && (arm_cnt_q == 3'(`FSPC_ARM_WINDOW - 1)); // R22
    // Clear beats a load in the same cycle: a load racing an eeprom write is lost anyway
    wire logic buf_clr = (done && ctl_q[`FSPC_BIT_WRITE]) || (st_go && is_reenable)
        || (eeprom_write_busy_bit && |valid_q); // R5 R7

    fspc_timer #(.CYCLES(PROG_CYCLES)) u_timer (
        .clk(clk),
        .nrst(nrst),
        .start(start_prog || start_lock),
        .done(done)
    );

    // ----------------------------------------
    // Control register and sequencing
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= FSPC_IDLE;
            ctl_q <= `FSPC_CTRL_RESET;
            arm_cnt_q <= 3'h0;
        end else begin
            case (st_q)
                FSPC_IDLE: begin
                    if (ctl_take) begin
                        ctl_q <= {ctrl_wr.data[7], 2'b00, ctrl_wr.data[4:0]};
                        arm_cnt_q <= 3'h0;
                        if (ctrl_wr.data[`FSPC_BIT_STORE_EN]) begin
                            st_q <= FSPC_ARMED;
                        end
                    end
                end
                FSPC_ARMED: begin
                    arm_cnt_q <= arm_cnt_q + 3'h1;
                    if (start_prog || start_lock) begin
                        st_q <= FSPC_BUSY;
                    end else if (st_go || arm_out) begin
                        ctl_q[4:0] <= 5'h00; // R22 R25
                        st_q <= FSPC_IDLE;
                    end
                end
                FSPC_BUSY: begin
                    if (done) begin
                        ctl_q[4:0] <= 5'h00; // R25
                        st_q <= FSPC_IDLE;
                    end
                end
                default: st_q <= FSPC_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Section busy and address capture
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy_q <= 1'b0;
            halt_sect_q <= 1'b0;
            prog <= '0;
        end else begin
            prog.go <= start_prog || start_lock;
            if (start_prog) begin
                busy_q <= 1'b1; // R11
                halt_sect_q <= page_no >= 16'(READ_WHILE_WRITE_PAGES); // R3 R9
                prog.addr <= store.addr; // R23
                prog.op <= is_erase ? fspc_pkg::FSPC_OP_ERASE : fspc_pkg::FSPC_OP_WRITE;
            end else if (start_lock) begin
                halt_sect_q <= 1'b0; // R16
                prog.addr <= 16'h0; // R14
                prog.op <= fspc_pkg::FSPC_OP_LOCK;
            end else if (st_go && is_reenable && st_q != FSPC_BUSY) begin
                busy_q <= 1'b0; // R12
            end
            // Halt ends with the operation; section busy waits for software
            if (done) begin
                halt_sect_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Page buffer, any load order
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            valid_q <= '0; // R5
        end else if (buf_clr) begin
            valid_q <= '0; // R5 R7
        end else if (st_go && is_load) begin
            valid_q[word_idx] <= 1'b1; // R20
        end
    end

    always_ff @(posedge clk) begin
        if (st_go && is_load) begin
            page_buf_q[word_idx] <= store.data; // R4
        end
    end

    // Cleared slots read as erased flash
    always_ff @(posedge clk) begin
        if (!nrst) begin
            buf_rd_q <= 16'hffff;
        end else begin
            buf_rd_q <= valid_q[buf_rd_idx] ? page_buf_q[buf_rd_idx] : 16'hffff;
        end
    end
    assign buf_rd_data = buf_rd_q;

    // ----------------------------------------
    // Lock bits and status outputs
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            boot_lock_bits <= `FSPC_LOCK_RESET;
        end else if (start_lock) begin
            boot_lock_bits <= boot_lock_bits & store.data[5:2]; // R14
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            flash_prog_control_reg <= `FSPC_CTRL_RESET;
            irq <= 1'b0;
            cpu_halt <= 1'b0;
            rww_read_block <= 1'b0;
            fuse_read_allow <= 1'b0;
        end else begin
            flash_prog_control_reg <= {ctl_q[7], busy_q, ctl_q[5:0]};
            irq <= ctl_q[`FSPC_BIT_IE] && !ctl_q[`FSPC_BIT_STORE_EN]; // R10
            cpu_halt <= halt_sect_q; // R3 R9
            rww_read_block <= busy_q; // R11
            fuse_read_allow <= fuse_read_req && !eeprom_write_busy_bit; // R17
        end
    end
endmodule

/* File: tb/fspc_assertions.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module fspc_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Core side
    input wire fspc_pkg::fspc_store_t store,
    input wire logic eeprom_write_busy_bit,
    // Status and array side
    input wire logic [7:0] flash_prog_control_reg,
    input wire logic irq,
    input wire logic cpu_halt,
    input wire logic rww_read_block,
    input wire logic fuse_read_allow,
    input wire logic [3:0] boot_lock_bits,
    input wire fspc_pkg::fspc_prog_t prog
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic armed = flash_prog_control_reg[0];
    a_go_store: assert property ($rose(prog.go) |-> $past(store.store))
        else $error("start without store");
    a_go_pulse: assert property (prog.go |=> !prog.go)
        else $error("start longer than one cycle");
    a_busy_block: assert property (rww_read_block == flash_prog_control_reg[6])
        else $error("read block differs from section busy");
    a_lock_free: assert property ((prog.go && prog.op == fspc_pkg::FSPC_OP_LOCK)
        |=> (!$rose(cpu_halt) && !$rose(rww_read_block))[*4]) else $error("lock blocked");
    a_fuse_block: assert property (eeprom_write_busy_bit && $past(eeprom_write_busy_bit)
        |-> !fuse_read_allow) else $error("fuse read during eeprom write");
    a_irq_level: assert property ((flash_prog_control_reg[7] && !armed)[*3] |-> irq)
        else $error("ready request missing");
    a_arm_expire: assert property (($rose(armed) && !$past(store.store))
        ##0 (!store.store)[*5] |-> !armed) else $error("arm did not expire");
    a_halt_cause: assert property ($rose(cpu_halt) |-> prog.go || $past(prog.go))
        else $error("halt without start");
    a_busy_hold: assert property ($fell(rww_read_block)
        |-> $past(store.store) || $past(store.store, 2) || $past(store.store, 3))
        else $error("section busy dropped without command");
    a_lock_only: assert property ((boot_lock_bits & ~$past(boot_lock_bits)) == 4'h0)
        else $error("lock bit returned to one");
    cover property (prog.go && prog.op == fspc_pkg::FSPC_OP_WRITE);
    cover property (cpu_halt);
    cover property (irq);
endmodule

bind fspc_ctrl fspc_assertions u_chk (.*);

/* File: tb/fspc_core_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Core issuing timed sequences
// ----------------------------------------
module fspc_core_model (
    // Clock
    input wire logic clk,
    // Core requests
    output fspc_pkg::fspc_ctrl_wr_t ctrl_wr,
    output fspc_pkg::fspc_store_t store
);
    initial begin
        ctrl_wr = '0;
        store = '0;
    end
    // Gap above 3 leaves the store out, to let the arm expire
    task spm(input logic [7:0] cmd, input logic [15:0] addr, input logic [15:0] data,
             input int gap);
        @(posedge clk);
        #1 ctrl_wr = {cmd, 1'b1};
        store.addr = addr;
        store.data = data;
        @(posedge clk);
        #1 ctrl_wr.wr = 1'b0;
        if (gap < 4) begin
            repeat (gap) begin
                @(posedge clk);
                #1;
            end
            store.store = 1'b1;
            @(posedge clk);
            #1 store.store = 1'b0;
        end
        // Stale values never linger on released lines
        store.addr = ~addr;
        store.data = ~data;
        ctrl_wr.data = ~cmd;
    endtask
endmodule

/* File: tb/fspc_ctrl_tb.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Testbench
// ----------------------------------------
module fspc_ctrl_tb;
    logic clk;
    logic nrst;
    fspc_pkg::fspc_ctrl_wr_t ctrl_wr;
    fspc_pkg::fspc_store_t store;
    logic [4:0] buf_rd_idx;
    logic eeprom_write_busy_bit;
    logic fuse_read_req;
    logic [7:0] flash_prog_control_reg;
    logic irq, cpu_halt, rww_read_block, fuse_read_allow;
    logic [3:0] boot_lock_bits;
    fspc_pkg::fspc_prog_t prog;
    fspc_pkg::fspc_prog_t last_go;
    logic [15:0] buf_rd_data;
    int num_errors = 0;
    int n_compared = 0;
    int n_go = 0;
    int g;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Short programming time keeps the run brief
    fspc_ctrl #(.PROG_CYCLES(20)) DUT (.*);
    fspc_core_model core (.clk(clk), .ctrl_wr(ctrl_wr), .store(store));
    always @(posedge clk) begin
        if (prog.go === 1'b1) begin
            n_go <= n_go + 1;
            last_go <= prog;
        end
    end
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task print_verdict;
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task wait_idle;
        int i;
        repeat (3) @(posedge clk);
        #1;
        // Look after the edge so the registered status has settled
        for (i = 0; i < 100 && flash_prog_control_reg[0] !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 100) begin
            num_errors++;
            print_verdict();
        end
    endtask
    task rd_buf(input logic [4:0] idx, input logic [15:0] exp);
        @(posedge clk);
        #1 buf_rd_idx = idx;
        @(posedge clk);
        #1 chk("buffer slot", buf_rd_data, exp);
    endtask
    task run(input logic [7:0] cmd, input logic [15:0] addr, input logic [15:0] data,
             input int gap);
        core.spm(cmd, addr, data, gap);
        wait_idle();
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
    initial begin
        nrst = 1'b0;
        buf_rd_idx = 5'h00;
        eeprom_write_busy_bit = 1'b0;
        fuse_read_req = 1'b1;
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        chk("lock bits", {12'h000, boot_lock_bits}, 16'h000f);
        chk("irq", {15'h0, irq}, 16'h0000);
        rd_buf(5'h00, 16'hffff);
        run(8'h01, 16'h000a, 16'h1234, 3);
        run(8'h01, 16'h0004, 16'habcd, 0);
        rd_buf(5'h05, 16'h1234);
        rd_buf(5'h02, 16'habcd);
        rd_buf(5'h07, 16'hffff);
        // Erase then write one page, then erase a page that halts the core
        for (int k = 0; k < 3; k++) begin
            core.spm((k == 1) ? 8'h05 : 8'h03, (k == 2) ? 16'hc000 : 16'h0100,
                16'h5555, 1);
            repeat (6) @(posedge clk);
            #1 chk("op", {14'h0, last_go.op}, {14'h0, (k == 1) ? fspc_pkg::FSPC_OP_WRITE
                : fspc_pkg::FSPC_OP_ERASE});
            chk("addr", last_go.addr, (k == 2) ? 16'hc000 : 16'h0100);
            chk("busy", {13'h0, rww_read_block, cpu_halt, flash_prog_control_reg[6]},
                (k == 2) ? 16'h0007 : 16'h0005);
            wait_idle();
            chk("section busy", {15'h0, flash_prog_control_reg[6]}, 16'h0001);
            if (k == 1)
                rd_buf(5'h05, 16'hffff);
        end
        run(8'h11, 16'h0000, 16'h0000, 2);
        chk("section busy", {15'h0, flash_prog_control_reg[6]}, 16'h0000);
        run(8'h09, 16'h0001, 16'h00eb, 2);
        chk("lock bits", {12'h000, boot_lock_bits}, 16'h000a);
        g = n_go;
        run(8'h03, 16'h0100, 16'h0000, 6);
        chk("expired start", 16'(n_go - g), 16'h0000);
        run(8'h81, 16'h0012, 16'h7777, 1);
        repeat (3) @(posedge clk);
        #1 chk("irq", {15'h0, irq}, 16'h0001);
        eeprom_write_busy_bit = 1'b1;
        g = n_go;
        core.spm(8'h03, 16'h0100, 16'h0000, 0);
        repeat (8) @(posedge clk);
        #1 chk("refused start", 16'(n_go - g), 16'h0000);
        chk("fuse read", {15'h0, fuse_read_allow}, 16'h0000);
        eeprom_write_busy_bit = 1'b0;
        rd_buf(5'h09, 16'hffff);
        chk("fuse read", {15'h0, fuse_read_allow}, 16'h0001);
        print_verdict();
    end
endmodule
